// ### src/fhrp_pkg.sv
package fhrp_pkg;

  localparam int unsigned DATA_W = 8;

  // register select codes
  localparam logic [1:0] SEL_STATUS_CMD = 2'h0;
  localparam logic [1:0] SEL_TRACK      = 2'h1;
  localparam logic [1:0] SEL_SECTOR     = 2'h2;
  localparam logic [1:0] SEL_DATA       = 2'h3;

  // reset values
  localparam logic [7:0] CMD_RESET_VAL    = 8'h03;
  localparam logic [7:0] SECTOR_RESET_VAL = 8'h01;
  localparam logic [7:0] TRACK_RESET_VAL  = 8'h00;
  localparam logic [7:0] BYTE_RESET_VAL   = 8'h00;

  // status field positions
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_REQ       = 1;
  localparam int unsigned ST_FLAGS_LO  = 2;
  localparam int unsigned ST_FLAGS_HI  = 6;
  localparam int unsigned ST_NOT_READY = 7;

  // pin sample vector layout
  localparam int unsigned PIN_W      = 14;
  localparam int unsigned PIN_HRST   = 13;
  localparam int unsigned PIN_CS     = 12;
  localparam int unsigned PIN_RE     = 11;
  localparam int unsigned PIN_WE     = 10;
  localparam int unsigned PIN_SEL_HI = 9;
  localparam int unsigned PIN_SEL_LO = 8;
  localparam int unsigned PIN_BUS_HI = 7;
  localparam int unsigned PIN_BUS_LO = 0;
  localparam logic [PIN_W-1:0] PIN_IDLE = 14'h3C00;

  typedef enum logic [1:0] {
    FHRP_IDLE    = 2'b00,
    FHRP_RESTORE = 2'b01,
    FHRP_BUSY    = 2'b11
  } fhrp_state_t;

endpackage : fhrp_pkg

// ### src/fhrp_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fhrp_stream_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fhrp_stream_if
`default_nettype wire

// ### src/fhrp_pair_buf.sv
`timescale 1ns/1ns
`default_nettype none
// two-entry buffer: full rate, registered read data, honest full and empty
module fhrp_pair_buf
  import fhrp_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      flush,
  fhrp_stream_if.snk     fill,
  fhrp_stream_if.src     drain
);

  logic [W-1:0] slot_reg [2];
  logic [W-1:0] head_reg;
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;
  logic [1:0]   count_next;
  wire          push = fill.valid & fill.ready;
  wire          pop  = drain.valid & drain.ready;
  wire          rd_ptr_next = pop ? ~rd_ptr_reg : rd_ptr_reg;

  assign fill.ready  = (count_reg != 2'h2);
  assign drain.valid = (count_reg != 2'h0);
  assign drain.data  = head_reg;

  always_comb begin
    count_next = count_reg;
    if (push & ~pop) count_next = count_reg + 2'h1;
    if (pop & ~push) count_next = count_reg - 2'h1;
  end

  always_ff @(posedge clk) begin
    if (push) slot_reg[wr_ptr_reg] <= fill.data;
  end

  // head register follows the oldest entry, bypassing a write into an empty slot
  always_ff @(posedge clk) begin
    if (push && (count_next == 2'h1 || count_reg == 2'h0) && wr_ptr_reg == rd_ptr_next) begin
      head_reg <= fill.data;
    end else begin
      head_reg <= slot_reg[rd_ptr_next];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst | flush) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      wr_ptr_reg <= push ? ~wr_ptr_reg : wr_ptr_reg;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

endmodule : fhrp_pair_buf
`default_nettype wire

// ### src/fhrp_host_port.sv
`timescale 1ns/1ns
`default_nettype none
module fhrp_host_port
  import fhrp_pkg::*;
#(
  parameter bit INVERT_BUS   = 1'b1,
  parameter bit SINGLE_DENS  = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              hard_reset_n,
  input  wire logic              chip_select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [1:0]        register_select,
  input  wire logic [DATA_W-1:0] host_bus_in,
  output logic      [DATA_W-1:0] host_bus_out,
  output logic                   host_bus_oe_n,
  output logic                   byte_service_request,
  output logic                   operation_done_irq,
  input  wire logic              density_select_n,
  output logic                   mfm_enable,
  input  wire logic              drive_not_ready,
  input  wire logic [4:0]        core_flags,
  input  wire logic              core_op_write,
  input  wire logic              core_op_done,
  output logic                   cmd_start,
  output logic      [DATA_W-1:0] cmd_code,
  output logic      [DATA_W-1:0] track_value,
  output logic      [DATA_W-1:0] sector_value,
  input  wire logic              disk_rd_valid,
  input  wire logic [DATA_W-1:0] disk_rd_data,
  output logic                   disk_rd_ready,
  output logic                   disk_wr_valid,
  output logic      [DATA_W-1:0] disk_wr_data,
  input  wire logic              disk_wr_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages two and three agree

  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_reg;
  logic [PIN_W-1:0] pin_next;
  wire  [PIN_W-1:0] pin_raw = {hard_reset_n, chip_select_n, read_strobe_n, write_strobe_n,
                               register_select, host_bus_in};

  assign pin_next = (~(pin_s2_reg ^ pin_s3_reg) & pin_s3_reg)
                  | ((pin_s2_reg ^ pin_s3_reg) & pin_reg);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      pin_s3_reg <= PIN_IDLE;
      pin_reg    <= PIN_IDLE;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg    <= pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  function automatic logic [DATA_W-1:0] bus_map(input logic [DATA_W-1:0] v);
    bus_map = INVERT_BUS ? ~v : v;
  endfunction : bus_map

  function automatic logic sel_is(input logic [1:0] sel, input logic [1:0] code);
    sel_is = (sel == code);
  endfunction : sel_is

  wire              hard_rst  = ~pin_reg[PIN_HRST] | sys_rst;
  wire              selected  = ~pin_reg[PIN_CS];
  wire              rd_act    = selected & ~pin_reg[PIN_RE];
  wire              wr_act    = selected & ~pin_reg[PIN_WE];
  wire [1:0]        sel       = pin_reg[PIN_SEL_HI:PIN_SEL_LO];
  wire [DATA_W-1:0] wr_byte   = bus_map(pin_reg[PIN_BUS_HI:PIN_BUS_LO]);

  logic rd_act_reg;
  logic wr_act_reg;
  logic [1:0] rd_sel_reg;
  wire  wr_go  = wr_act & ~wr_act_reg;
  wire  rd_end = rd_act_reg & ~rd_act;

  wire  wr_cmd    = wr_go & sel_is(sel, SEL_STATUS_CMD);
  wire  wr_track  = wr_go & sel_is(sel, SEL_TRACK);
  wire  wr_sector = wr_go & sel_is(sel, SEL_SECTOR);
  wire  wr_data   = wr_go & sel_is(sel, SEL_DATA);
  wire  rd_status = rd_end & sel_is(rd_sel_reg, SEL_STATUS_CMD);
  wire  rd_data   = rd_end & sel_is(rd_sel_reg, SEL_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // operation state

  fhrp_state_t state_reg;
  fhrp_state_t state_next;
  logic        hard_rst_reg;
  logic        irq_reg;
  logic        busy;

  always_comb begin
    case (state_reg)
      FHRP_IDLE:    state_next = wr_cmd ? FHRP_BUSY : FHRP_IDLE;
      FHRP_RESTORE: state_next = FHRP_BUSY;
      FHRP_BUSY:    state_next = core_op_done ? FHRP_IDLE : FHRP_BUSY;
      default:      state_next = FHRP_IDLE;
    endcase
  end

  assign busy = (state_reg == FHRP_BUSY);

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      state_reg <= FHRP_RESTORE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    hard_rst_reg <= hard_rst;
  end

  // restore launched on release, whatever the drive reports
  assign cmd_start = (~hard_rst & hard_rst_reg) | (wr_cmd & ~busy);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [DATA_W-1:0] cmd_reg;
  logic [DATA_W-1:0] track_reg;
  logic [DATA_W-1:0] sector_reg;
  logic [DATA_W-1:0] wbyte_reg;
  logic              wpend_reg;

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      cmd_reg    <= CMD_RESET_VAL;
      sector_reg <= SECTOR_RESET_VAL;
      track_reg  <= TRACK_RESET_VAL;
      wbyte_reg  <= BYTE_RESET_VAL;
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      rd_sel_reg <= SEL_STATUS_CMD;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      rd_sel_reg <= sel;
      if (wr_cmd & ~busy) cmd_reg <= wr_byte;
      if (wr_track) track_reg <= wr_byte;
      if (wr_sector) sector_reg <= wr_byte;
      if (wr_data) wbyte_reg <= wr_byte;
    end
  end

  // set wins over clear on the same edge
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      irq_reg   <= 1'b0;
      wpend_reg <= 1'b0;
    end else begin
      irq_reg   <= (busy & core_op_done) | (irq_reg & ~(wr_cmd | rd_status));
      wpend_reg <= wr_data | (wpend_reg & ~disk_wr_ready);
    end
  end

  assign cmd_code      = cmd_reg;
  assign track_value   = track_reg;
  assign sector_value  = sector_reg;
  assign disk_wr_valid = wpend_reg;
  assign disk_wr_data  = wbyte_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data path through the two-entry buffer

  fhrp_stream_if #(.W(DATA_W)) rd_in ();
  fhrp_stream_if #(.W(DATA_W)) rd_out ();

  assign rd_in.valid   = disk_rd_valid;
  assign rd_in.data    = disk_rd_data;
  assign disk_rd_ready = rd_in.ready;
  assign rd_out.ready  = rd_data;

  fhrp_pair_buf #(.W(DATA_W)) u_rd_buf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .flush   (hard_rst),
    .fill    (rd_in),
    .drain   (rd_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status, request and read mux

  wire               svc_req = busy & (core_op_write ? ~wpend_reg : rd_out.valid);
  wire  [DATA_W-1:0] status  = {drive_not_ready & ~hard_rst, core_flags,
                                svc_req, busy};
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rd_out_reg;

  assign rd_mux = sel_is(sel, SEL_STATUS_CMD) ? status     :
                  sel_is(sel, SEL_TRACK)      ? track_reg  :
                  sel_is(sel, SEL_SECTOR)     ? sector_reg : rd_out.data;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_out_reg <= BYTE_RESET_VAL;
    end else if (rd_act) begin
      rd_out_reg <= bus_map(rd_mux);
    end
  end

  assign host_bus_out         = rd_out_reg;
  assign host_bus_oe_n        = ~(rd_act & rd_act_reg);
  assign byte_service_request = svc_req;
  assign operation_done_irq   = irq_reg;
  assign mfm_enable           = ~SINGLE_DENS & ~density_select_n;

endmodule : fhrp_host_port
`default_nettype wire

// ### tb/fhrp_host_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fhrp_host_port_checker
  import fhrp_pkg::*;
#(
  parameter bit SINGLE_DENS = 1'b0
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              hard_reset_n,
  input wire logic              chip_select_n,
  input wire logic              read_strobe_n,
  input wire logic              host_bus_oe_n,
  input wire logic              byte_service_request,
  input wire logic              operation_done_irq,
  input wire logic              density_select_n,
  input wire logic              mfm_enable,
  input wire logic              core_op_done,
  input wire logic              cmd_start,
  input wire logic [DATA_W-1:0] cmd_code,
  input wire logic [DATA_W-1:0] track_value,
  input wire logic [DATA_W-1:0] sector_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence hrst_release_s;
    !hard_reset_n [*8] ##1 hard_reset_n;
  endsequence
  sequence rd_held_s;
    (!chip_select_n && !read_strobe_n) [*8];
  endsequence
  AST_RESTORE: assert property (hrst_release_s |-> ##[1:10] (cmd_start && cmd_code == 8'h03))
    else $error("restore not started after hard reset");
  AST_PRESET: assert property (hrst_release_s |-> ##2 (sector_value == 8'h01 && track_value == 8'h00))
    else $error("sector preset missing");
  AST_HARD_QUIET: assert property (!hard_reset_n [*8] |-> host_bus_oe_n && !operation_done_irq && !byte_service_request)
    else $error("outputs active in hard reset");
  AST_DESEL: assert property (chip_select_n [*8] |-> host_bus_oe_n)
    else $error("bus driven while deselected");
  AST_NO_RD_NO_DRIVE: assert property (read_strobe_n [*8] |-> host_bus_oe_n)
    else $error("bus driven without read strobe");
  AST_RD_DRIVE: assert property (rd_held_s |-> !host_bus_oe_n)
    else $error("bus not driven on read");
  AST_DENSITY: assert property (mfm_enable == (!SINGLE_DENS && !density_select_n))
    else $error("density select wrong");
  AST_IRQ_SET: assert property (core_op_done |-> ##[1:2] operation_done_irq)
    else $error("irq not set on completion");
  AST_IRQ_CLR: assert property (cmd_start && !core_op_done |-> ##[0:1] !operation_done_irq)
    else $error("irq not cleared by command");
endmodule : fhrp_host_port_checker
bind fhrp_host_port fhrp_host_port_checker #(.SINGLE_DENS(SINGLE_DENS)) fhrp_host_port_checker_i (
  .clk, .sys_rst, .hard_reset_n, .chip_select_n, .read_strobe_n, .host_bus_oe_n,
  .byte_service_request, .operation_done_irq, .density_select_n, .mfm_enable,
  .core_op_done, .cmd_start, .cmd_code, .track_value, .sector_value);
`default_nettype wire

// ### tb/fhrp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fhrp_host_model #(
  parameter bit INV = 1'b1
) (
  input  wire logic       clk,
  input  wire logic [7:0] host_bus_out,
  input  wire logic       host_bus_oe_n,
  output logic            chip_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic      [1:0] register_select,
  output logic      [7:0] host_bus_in,
  output logic            rd_done,
  output logic      [7:0] rd_data
);
  logic [7:0] drv;
  logic [7:0] last = 8'h00;
  logic       drv_en;
  // a released bus shows a changing pattern, never a stale byte
  assign host_bus_in = drv_en ? drv : (!host_bus_oe_n ? host_bus_out : ~last);
  always @(posedge clk) last <= host_bus_in;
  initial begin
    {chip_select_n, read_strobe_n, write_strobe_n, drv_en, rd_done} = 5'h1C;
    {register_select, drv, rd_data} = 18'h0;
  end
  task automatic access(input logic cs, input logic wr, input logic [1:0] s,
                        input logic [7:0] v);
    @(posedge clk);
    #1 chip_select_n = !cs;
    register_select = s;
    drv = INV ? ~v : v;
    drv_en = wr;
    read_strobe_n = wr;
    write_strobe_n = !wr;
    repeat (10) @(posedge clk);
    rd_data = INV ? ~host_bus_in : host_bus_in;
    #1 {chip_select_n, read_strobe_n, write_strobe_n, drv_en} = 4'hE;
    rd_done = cs && !wr;
    @(posedge clk);
    #1 rd_done = 0;
    repeat (5) @(posedge clk);
  endtask : access
endmodule : fhrp_host_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import fhrp_pkg::*;
  logic clk = 0, sys_rst = 1, hard_reset_n = 1, density_select_n = 1, drive_not_ready = 1;
  logic core_op_write = 0, core_op_done = 0, disk_rd_valid = 0, disk_wr_ready = 0;
  logic [7:0] disk_rd_data = 0, host_bus_in, host_bus_out, cmd_code, track_value;
  logic [7:0] sector_value, disk_wr_data, rd_data, v, got, exp_v;
  logic [4:0] core_flags = 0;
  logic [1:0] register_select;
  logic chip_select_n, read_strobe_n, write_strobe_n, host_bus_oe_n, byte_service_request;
  logic operation_done_irq, mfm_enable, cmd_start, disk_rd_ready, disk_wr_valid, rd_done;
  logic [7:0] exp_q[$];
  integer seed = 39304, err_count = 0, num_checks = 0;
  always #20 clk = ~clk;
  fhrp_host_port fhrp_host_port_i (.clk, .sys_rst, .hard_reset_n, .chip_select_n,
    .read_strobe_n, .write_strobe_n, .register_select, .host_bus_in, .host_bus_out,
    .host_bus_oe_n, .byte_service_request, .operation_done_irq, .density_select_n,
    .mfm_enable, .drive_not_ready, .core_flags, .core_op_write, .core_op_done, .cmd_start,
    .cmd_code, .track_value, .sector_value, .disk_rd_valid, .disk_rd_data, .disk_rd_ready,
    .disk_wr_valid, .disk_wr_data, .disk_wr_ready);
  fhrp_host_model fhrp_host_model_i (.clk, .host_bus_out, .host_bus_oe_n, .chip_select_n,
    .read_strobe_n, .write_strobe_n, .register_select, .host_bus_in, .rd_done, .rd_data);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic cs, input logic wr, input logic [1:0] s, input logic [7:0] d);
    if (cs && !wr) exp_q.push_back(d);
    fhrp_host_model_i.access(cs, wr, s, d);
  endtask : acc
  task automatic push(input logic [7:0] d);
    disk_rd_valid = 1;
    disk_rd_data = d;
    for (int n = 0; n < 50 && disk_rd_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : push
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_done === 1'b1 || (disk_wr_valid === 1'b1 && disk_wr_ready === 1'b1)) begin
      got = rd_done ? rd_data : disk_wr_data;
      `CHK(exp_q.size() > 0, 1'b1)
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : ~got;
      `CHK(got, exp_v)
    end
  end
  // far side stalls at random; density pin wanders
  always @(posedge clk) begin
    #1 disk_wr_ready = $random(seed);
    density_select_n = $random(seed);
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  initial begin
    core_flags = $random(seed);
    drive_not_ready = $random(seed);
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    acc(1, 1, SEL_SECTOR, 8'h77);
    #1 hard_reset_n = 0;
    repeat (12) @(posedge clk);
    #1 hard_reset_n = 1;
    repeat (20) @(posedge clk);
    #1 `CHK(cmd_code, 8'h03)
    acc(1, 0, SEL_SECTOR, 8'h01);
    acc(1, 0, SEL_TRACK, 8'h00);
    $display("test hard_reset done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      acc(1, 1, i[0] ? SEL_TRACK : SEL_SECTOR, v);
      acc(0, 1, i[0] ? SEL_TRACK : SEL_SECTOR, ~v);
      acc(1, 0, i[0] ? SEL_TRACK : SEL_SECTOR, v);
    end
    $display("test registers done");
    #1 push(8'hC3);
    push(8'h3C);
    disk_rd_valid = 0;
    `CHK(disk_rd_ready, 1'b0)
    `CHK(byte_service_request, 1'b1)
    acc(1, 0, SEL_DATA, 8'hC3);
    acc(1, 0, SEL_DATA, 8'h3C);
    #1 `CHK(byte_service_request, 1'b0)
    $display("test read buffer done");
    core_op_done = 1;
    @(posedge clk);
    #1 core_op_done = 0;
    repeat (3) @(posedge clk);
    #1 `CHK(operation_done_irq, 1'b1)
    acc(1, 0, SEL_STATUS_CMD, {drive_not_ready, core_flags, 2'b00});
    #1 `CHK(operation_done_irq, 1'b0)
    $display("test irq done");
    #1 core_op_write = 1;
    acc(1, 1, SEL_STATUS_CMD, 8'hA5);
    #1 `CHK(cmd_code, 8'hA5)
    `CHK(byte_service_request, 1'b1)
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      exp_q.push_back(v);
      acc(1, 1, SEL_DATA, v);
    end
    repeat (30) @(posedge clk);
    #1 `CHK(exp_q.size(), 0)
    $display("test write stream done");
    core_op_done = 1;
    @(posedge clk);
    #1 core_op_done = 0;
    repeat (3) @(posedge clk);
    #1 `CHK(operation_done_irq, 1'b1)
    acc(1, 1, SEL_STATUS_CMD, 8'h5A);
    #1 `CHK(operation_done_irq, 1'b0)
    `CHK(cmd_code, 8'h5A)
    $display("test irq by command done");
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
